// ==== ago_pkg.sv ====
package ago_pkg;

  // Parallel host bus
  localparam int DATA_W = 14;
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_RESULT = 2'h0;
  localparam logic [1:0] ADDR_GAIN = 2'h1;
  localparam logic [1:0] ADDR_OFFSET = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;

  // Field layouts
  localparam int GAIN_W = 3;
  localparam int OFFS_W = 8;
  localparam int TM_W = 3;
  localparam int CTRL_PWD = 13;
  localparam int CTRL_REF = 12;
  localparam int CTRL_FMT = 11;
  localparam int CTRL_TM_LSB = 8;
  localparam int CTRL_OFF = 7;
  localparam logic [13:0] CTRL_MASK = 14'h3F80;

  // Reset values
  localparam logic [2:0] GAIN_RST = 3'h0;
  localparam logic [7:0] OFFS_RST = 8'h00;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [13:0] DOUT_RST = 14'h0000;

  // Test input codes that leave the converter on the external signal
  localparam logic [2:0] TM_NORMAL_A = 3'h0;
  localparam logic [2:0] TM_NORMAL_B = 3'h4;

  // Pin synchroniser: cs_n, wr_n, rd_n, oe_n, addr, data
  localparam int PIN_W = 4 + ADDR_W + DATA_W;
  localparam logic [19:0] PIN_IDLE = 20'hF_0000;

  // Result buffer
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = DATA_W + 1;

endpackage

// ==== ago_fifo_if.sv ====
`timescale 1ns/1ps
interface ago_fifo_if #(parameter int W = 15);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport src (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );

  modport fifo (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );
endinterface

// ==== ago_fifo.sv ====
`timescale 1ns/1ps
module ago_fifo #(
  parameter int W = 15,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Buffer channel
  ago_fifo_if.fifo ch
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
    begin : g_bad
      $error("ago_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW-1:0] nxt_rd_ptr;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic [W-1:0] head_ff;
  logic [W-1:0] nxt_head;
  logic head_valid_ff;
  logic nxt_head_valid;
  logic push;
  logic pop;

  assign ch.in_ready = (count_ff != (AW+1)'(DEPTH));
  assign ch.out_valid = head_valid_ff;
  assign ch.out_data = head_ff;
  assign push = ch.in_valid && ch.in_ready;
  assign pop = head_valid_ff && ch.out_ready;

  // Head is kept in a register; a word written into an empty slot that is
  // also the next head is forwarded so the output never shows stale data
  always_comb
  begin
    nxt_wr_ptr = wr_ptr_ff + AW'(push);
    nxt_rd_ptr = rd_ptr_ff + AW'(pop);
    nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_head_valid = (nxt_count != '0);
    if (push && (wr_ptr_ff == nxt_rd_ptr))
      nxt_head = ch.in_data;
    else
      nxt_head = mem[nxt_rd_ptr];
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_ff] <= ch.in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      head_ff <= '0;
      head_valid_ff <= 1'b0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      head_ff <= nxt_head;
      head_valid_ff <= nxt_head_valid;
    end
  end
endmodule

// ==== ago_top.sv ====
`timescale 1ns/1ps
module ago_top #(
  parameter int FIFO_DEPTH = ago_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host parallel bus
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic oe_n,
  input wire logic [ago_pkg::ADDR_W-1:0] addr,
  input wire logic [ago_pkg::DATA_W-1:0] data_i,
  output logic [ago_pkg::DATA_W-1:0] data_o,
  output logic data_oe,
  // Converter core results
  input wire logic [ago_pkg::DATA_W-1:0] core_sample,
  input wire logic core_range_raw,
  input wire logic core_valid,
  output logic core_ready,
  // Analog front-end controls
  output logic ext_ref_sel,
  output logic [ago_pkg::GAIN_W-1:0] gain_step_code,
  output logic [ago_pkg::TM_W-1:0] test_input_select,
  output logic test_active,
  output logic power_down,
  // Status that accompanies each result
  output logic range_exceeded_flag
);
  localparam int DW = ago_pkg::DATA_W;
  localparam int PW = ago_pkg::PIN_W;

  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256)
    begin : g_bad
      $error("ago_top: FIFO_DEPTH out of range");
    end
  endgenerate

  // Pin synchroniser, three stages then agreement filter
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] s1_ff;
  logic [PW-1:0] s2_ff;
  logic [PW-1:0] s3_ff;
  logic [PW-1:0] filt_ff;
  logic [PW-1:0] nxt_filt;
  logic [PW-1:0] prev_ff;

  assign pin_raw = {cs_n, wr_n, rd_n, oe_n, addr, data_i};

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++)
    begin : g_filt
      assign nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi]
                                                     : filt_ff[gi];
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      s1_ff <= ago_pkg::PIN_IDLE;
      s2_ff <= ago_pkg::PIN_IDLE;
      s3_ff <= ago_pkg::PIN_IDLE;
      filt_ff <= ago_pkg::PIN_IDLE;
      prev_ff <= ago_pkg::PIN_IDLE;
    end
    else
    begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
    end
  end

  // Filtered pin fields
  logic cs_prev_n;
  logic wr_now_n;
  logic wr_prev_n;
  logic rd_now_n;
  logic rd_prev_n;
  logic oe_now_n;
  logic [ago_pkg::ADDR_W-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic wr_evt;
  logic rd_evt;

  assign cs_prev_n = prev_ff[PW-1];
  assign wr_now_n = filt_ff[PW-2];
  assign wr_prev_n = prev_ff[PW-2];
  assign rd_now_n = filt_ff[PW-3];
  assign rd_prev_n = prev_ff[PW-3];
  assign oe_now_n = filt_ff[PW-4];
  assign addr_q = prev_ff[DW +: ago_pkg::ADDR_W];
  assign data_q = prev_ff[DW-1:0];
  // Write lands on the trailing edge of wr_n, when data has settled
  assign wr_evt = wr_now_n && !wr_prev_n && !cs_prev_n;
  assign rd_evt = !rd_now_n && rd_prev_n && !cs_prev_n;

  // Register file
  logic [ago_pkg::GAIN_W-1:0] gain_ff;
  logic [ago_pkg::GAIN_W-1:0] nxt_gain;
  logic [ago_pkg::OFFS_W-1:0] offs_ff;
  logic [ago_pkg::OFFS_W-1:0] nxt_offs;
  logic [DW-1:0] ctrl_ff;
  logic [DW-1:0] nxt_ctrl;

  always_comb
  begin
    nxt_gain = gain_ff;
    nxt_offs = offs_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_evt)
    begin
      case (addr_q)
        ago_pkg::ADDR_GAIN: nxt_gain = data_q[ago_pkg::GAIN_W-1:0];
        ago_pkg::ADDR_OFFSET: nxt_offs = data_q[ago_pkg::OFFS_W-1:0];
        ago_pkg::ADDR_CTRL: nxt_ctrl = data_q & ago_pkg::CTRL_MASK;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      gain_ff <= ago_pkg::GAIN_RST;
      offs_ff <= ago_pkg::OFFS_RST;
      ctrl_ff <= ago_pkg::CTRL_RST;
    end
    else
    begin
      gain_ff <= nxt_gain;
      offs_ff <= nxt_offs;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Sample stage: offset correction with saturation
  logic stage_valid_ff;
  logic nxt_stage_valid;
  logic [DW:0] stage_ff;
  logic [DW:0] nxt_stage;
  logic core_ready_ff;
  logic nxt_core_ready;
  logic take;
  logic corr_en;
  logic [DW:0] diff;
  logic [DW-1:0] corrected;

  ago_fifo_if #(.W(ago_pkg::FIFO_W)) buf_ch ();

  assign take = core_valid && core_ready_ff;
  assign corr_en = !ctrl_ff[ago_pkg::CTRL_OFF];

  always_comb
  begin
    diff = {core_sample[DW-1], core_sample}
         - {{(DW+1-ago_pkg::OFFS_W){offs_ff[ago_pkg::OFFS_W-1]}},
            offs_ff};
    if (!corr_en)
      corrected = core_sample;
    else if (diff[DW] != diff[DW-1])
      corrected = {diff[DW], {(DW-1){!diff[DW]}}};
    else
      corrected = diff[DW-1:0];
    nxt_stage = stage_ff;
    nxt_stage_valid = stage_valid_ff;
    if (stage_valid_ff && buf_ch.in_ready)
      nxt_stage_valid = 1'b0;
    if (take)
    begin
      // Flag is sampled per result, never held over from earlier ones
      nxt_stage = {core_range_raw, corrected};
      nxt_stage_valid = 1'b1;
    end
    // Half-rate acceptance keeps ready a plain flop; far above sample rate
    nxt_core_ready = !nxt_stage_valid;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      stage_ff <= '0;
      stage_valid_ff <= 1'b0;
      core_ready_ff <= 1'b0;
    end
    else
    begin
      stage_ff <= nxt_stage;
      stage_valid_ff <= nxt_stage_valid;
      core_ready_ff <= nxt_core_ready;
    end
  end

  assign buf_ch.in_valid = stage_valid_ff;
  assign buf_ch.in_data = stage_ff;
  assign buf_ch.out_ready = rd_evt && (addr_q == ago_pkg::ADDR_RESULT);

  ago_fifo #(
    .W(ago_pkg::FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .ch(buf_ch.fifo)
  );

  // Read path and output pins
  logic [DW-1:0] dout_ff;
  logic [DW-1:0] nxt_dout;
  logic flag_ff;
  logic nxt_flag;
  logic oe_ff;
  logic nxt_oe;
  logic [DW-1:0] result_fmt;

  // Straight binary flips the sign bit of the two's complement result
  assign result_fmt = ctrl_ff[ago_pkg::CTRL_FMT]
                    ? buf_ch.out_data[DW-1:0]
                    : {!buf_ch.out_data[DW-1], buf_ch.out_data[DW-2:0]};

  always_comb
  begin
    nxt_dout = dout_ff;
    nxt_flag = flag_ff;
    nxt_oe = !oe_now_n;
    if (rd_evt)
    begin
      case (addr_q)
        ago_pkg::ADDR_RESULT:
        begin
          if (buf_ch.out_valid)
          begin
            nxt_dout = result_fmt;
            nxt_flag = buf_ch.out_data[DW];
          end
        end
        ago_pkg::ADDR_GAIN:
          nxt_dout = {{(DW-ago_pkg::GAIN_W){1'b0}}, gain_ff};
        ago_pkg::ADDR_OFFSET:
          nxt_dout = {{(DW-ago_pkg::OFFS_W){1'b0}}, offs_ff};
        ago_pkg::ADDR_CTRL:
          nxt_dout = ctrl_ff;
        default:
          nxt_dout = dout_ff;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dout_ff <= ago_pkg::DOUT_RST;
      flag_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      dout_ff <= nxt_dout;
      flag_ff <= nxt_flag;
      oe_ff <= nxt_oe;
    end
  end

  // Analog controls, registered from the control fields and the gain register
  logic ref_ff;
  logic [ago_pkg::GAIN_W-1:0] gcode_ff;
  logic [ago_pkg::TM_W-1:0] tm_ff;
  logic tact_ff;
  logic pwd_ff;
  logic nxt_ref;
  logic [ago_pkg::TM_W-1:0] nxt_tm;
  logic nxt_tact;
  logic nxt_pwd;

  always_comb
  begin
    nxt_ref = nxt_ctrl[ago_pkg::CTRL_REF];
    nxt_tm = nxt_ctrl[ago_pkg::CTRL_TM_LSB +: ago_pkg::TM_W];
    nxt_tact = (nxt_tm != ago_pkg::TM_NORMAL_A)
            && (nxt_tm != ago_pkg::TM_NORMAL_B);
    nxt_pwd = nxt_ctrl[ago_pkg::CTRL_PWD];
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ref_ff <= 1'b0;
      gcode_ff <= ago_pkg::GAIN_RST;
      tm_ff <= '0;
      tact_ff <= 1'b0;
      pwd_ff <= 1'b0;
    end
    else
    begin
      ref_ff <= nxt_ref;
      gcode_ff <= nxt_gain;
      tm_ff <= nxt_tm;
      tact_ff <= nxt_tact;
      pwd_ff <= nxt_pwd;
    end
  end

  assign data_o = dout_ff;
  assign data_oe = oe_ff;
  assign range_exceeded_flag = flag_ff;
  assign core_ready = core_ready_ff;
  assign ext_ref_sel = ref_ff;
  assign gain_step_code = gcode_ff;
  assign test_input_select = tm_ff;
  assign test_active = tact_ff;
  assign power_down = pwd_ff;
endmodule

// ==== ago_top_monitor.sv ====
`timescale 1ns/1ps
module ago_top_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host bus
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic oe_n,
  input wire logic [1:0] addr,
  input wire logic [13:0] data_o,
  input wire logic data_oe,
  // Stream, controls and status
  input wire logic core_valid,
  input wire logic core_ready,
  input wire logic ext_ref_sel,
  input wire logic [2:0] gain_step_code,
  input wire logic [2:0] test_input_select,
  input wire logic test_active,
  input wire logic range_exceeded_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_oe_drives: assert property (!oe_n [*8] |-> data_oe)
    else $error("pins not driven");
  a_oe_quiet: assert property (oe_n [*8] |-> !data_oe)
    else $error("pins driven");
  a_test_flag: assert property
    (test_active == (test_input_select[1:0] != 2'b00))
    else $error("test flag wrong");
  a_ready_gap: assert property
    (core_valid && core_ready |=> !core_ready)
    else $error("ready gap");
  a_read_only: assert property
    ($changed(data_o) |-> !$past(rd_n, 3))
    else $error("data without read");
  a_flag_read: assert property
    ($changed(range_exceeded_flag) |-> !$past(rd_n, 3)
      && $past(addr, 3) == ago_pkg::ADDR_RESULT)
    else $error("flag without read");
  a_ref_write: assert property
    ($changed(ext_ref_sel) |-> $past(wr_n, 2) && !$past(wr_n, 10)
      && $past(addr, 2) == ago_pkg::ADDR_CTRL)
    else $error("ref without write");
  a_gain_write: assert property
    ($changed(gain_step_code) |-> $past(wr_n, 2)
      && $past(addr, 2) == ago_pkg::ADDR_GAIN)
    else $error("gain without write");
  a_test_write: assert property
    ($changed(test_input_select) |-> !$past(wr_n, 10)
      && $past(addr, 2) == ago_pkg::ADDR_CTRL)
    else $error("test without write");
endmodule

bind ago_top ago_top_monitor mon_u (.mclk(mclk), .nrst(nrst),
  .wr_n(wr_n), .rd_n(rd_n), .oe_n(oe_n), .addr(addr),
  .data_o(data_o), .data_oe(data_oe), .core_valid(core_valid),
  .core_ready(core_ready), .ext_ref_sel(ext_ref_sel),
  .gain_step_code(gain_step_code),
  .test_input_select(test_input_select), .test_active(test_active),
  .range_exceeded_flag(range_exceeded_flag));

// ==== ago_host_model.sv ====
`timescale 1ns/1ps
module ago_host_model (
  // Clock
  input wire logic mclk,
  // Host bus pins
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic oe_n,
  output logic [1:0] addr,
  output logic [13:0] data_i,
  input wire logic [13:0] data_o
);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    oe_n = 1'b1;
    addr = 2'h0;
    data_i = 14'h0000;
  end

  // Strobes are long so the pin synchroniser sees every edge
  task automatic wr(input logic [1:0] a, input logic [13:0] d);
    addr <= a;
    data_i <= d;
    cs_n <= 1'b0;
    repeat (7) @(posedge mclk);
    wr_n <= 1'b0;
    repeat (8) @(posedge mclk);
    wr_n <= 1'b1;
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    data_i <= ~d;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [1:0] a, output logic [13:0] d);
    addr <= a;
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    repeat (7) @(posedge mclk);
    rd_n <= 1'b0;
    repeat (10) @(posedge mclk);
    d = data_o;
    rd_n <= 1'b1;
    oe_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// ==== ago_top_tb_top.sv ====
`timescale 1ns/1ps
module ago_top_tb_top;
  logic mclk, nrst, cs_n, wr_n, rd_n, oe_n, data_oe;
  logic [1:0] addr;
  logic [13:0] data_i, data_o, core_sample, rd_v;
  logic core_range_raw, core_valid, core_ready;
  logic ext_ref_sel, test_active, power_down, flag;
  logic [2:0] gain_step_code, test_input_select;
  int n_fail, n_compared;

  ago_top #(.FIFO_DEPTH(8)) dut_u (.mclk(mclk), .nrst(nrst),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .oe_n(oe_n), .addr(addr),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
    .core_sample(core_sample), .core_range_raw(core_range_raw),
    .core_valid(core_valid), .core_ready(core_ready),
    .ext_ref_sel(ext_ref_sel), .gain_step_code(gain_step_code),
    .test_input_select(test_input_select), .test_active(test_active),
    .power_down(power_down), .range_exceeded_flag(flag));
  ago_host_model host_u (.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .oe_n(oe_n), .addr(addr), .data_i(data_i),
    .data_o(data_o));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [13:0] e,
    input logic [13:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic push(input logic [13:0] s, input logic r);
    int k;
    core_sample <= s;
    core_range_raw <= r;
    core_valid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge mclk);
      if (core_ready === 1'b1)
        break;
    end
    @(posedge mclk);
    core_valid <= 1'b0;
    @(posedge mclk);
    if (k == 40)
    begin
      chk("ready", 14'h0001, 14'h0000);
      report_and_stop();
    end
  endtask

  task automatic rd_chk(input logic [13:0] e, input logic f);
    host_u.rd(2'h0, rd_v);
    chk("result", e, rd_v);
    chk("flag", {13'h0, f}, {13'h0, flag});
  endtask

  task automatic t_gain();
    for (int g = 0; g < 8; g++)
    begin
      host_u.wr(2'h1, 14'h3FF8 | 14'(g));
      chk("gain", 14'(g), {11'h0, gain_step_code});
    end
    host_u.rd(2'h1, rd_v);
    chk("gain_rd", 14'h0007, rd_v);
    $display("t_gain done");
  endtask

  task automatic t_ctrl();
    logic [13:0] v;
    for (int t = 0; t < 8; t++)
    begin
      v = (14'(t) << 8) | (t[0] ? 14'h1000 : 14'h0000) | 14'h007F
        | (t[1] ? 14'h2000 : 14'h0000);
      host_u.wr(2'h3, v);
      chk("tm", 14'(t), {11'h0, test_input_select});
      chk("tact", {13'h0, t % 4 != 0}, {13'h0, test_active});
      chk("ref", {13'h0, t[0]}, {13'h0, ext_ref_sel});
      chk("pwd", {13'h0, t[1]}, {13'h0, power_down});
    end
    host_u.rd(2'h3, rd_v);
    chk("ctrl_rd", v & 14'h3F80, rd_v);
    $display("t_ctrl done");
  endtask

  task automatic t_offset();
    // Zero-input result becomes the correction value
    host_u.wr(2'h3, 14'h0800);
    push(14'h0005, 1'b0);
    host_u.rd(2'h0, rd_v);
    chk("zero_in", 14'h0005, rd_v);
    host_u.wr(2'h2, rd_v);
    push(14'h0005, 1'b1);
    rd_chk(14'h0000, 1'b1);
    push(14'h0064, 1'b0);
    rd_chk(14'h005F, 1'b0);
    host_u.wr(2'h2, 14'h3FF8);
    host_u.rd(2'h2, rd_v);
    chk("offs_rd", 14'h00F8, rd_v);
    push(14'h0064, 1'b0);
    rd_chk(14'h006C, 1'b0);
    // Positive overflow of the correction must clip, not wrap
    push(14'h1FFF, 1'b0);
    rd_chk(14'h1FFF, 1'b0);
    host_u.wr(2'h3, 14'h0880);
    push(14'h0064, 1'b1);
    rd_chk(14'h0064, 1'b1);
    host_u.wr(2'h3, 14'h0080);
    push(14'h0064, 1'b0);
    rd_chk(14'h2064, 1'b0);
    $display("t_offset done");
  endtask

  task automatic t_fifo();
    int k;
    host_u.wr(2'h3, 14'h0880);
    for (int i = 0; i < 9; i++)
      push(14'h0100 + 14'(i), i[0]);
    // Buffer and stage are full, so the core must be held off
    core_valid <= 1'b1;
    k = 0;
    repeat (20)
    begin
      @(negedge mclk);
      k += int'(core_ready === 1'b1);
    end
    @(posedge mclk);
    core_valid <= 1'b0;
    chk("full", 14'h0000, 14'(k));
    for (int i = 0; i < 9; i++)
      rd_chk(14'h0100 + 14'(i), i[0]);
    rd_chk(14'h0108, 1'b0);
    $display("t_fifo done");
  endtask

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    nrst = 1'b0;
    core_valid = 1'b0;
    core_sample = 14'h0000;
    core_range_raw = 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (6) @(posedge mclk);
    t_gain();
    t_ctrl();
    t_offset();
    t_fifo();
    report_and_stop();
  end
endmodule
